// >>> bench/asr_host_model.sv
// host controller model: drives shift clock, frame strobe and chain input, samples the serial outputs
`timescale 1ns/10ps

module asr_host_model #(
	parameter int NCH = 8
) (
	// master clock that times the link
	input  wire logic           clk_i,
	// link pins toward the port
	output logic                sclk_o,
	output logic                frame_o,
	output logic                chain_o,
	input  wire logic [NCH-1:0] dout_i
);
	// ======================================================================
	// idle: shift clock stopped low between reads, strobe low, chain line driven low
	initial begin
		sclk_o  = 1'b0;
		frame_o = 1'b0;
		chain_o = 1'b0;
	end

	// ======================================================================
	// one bit of 8 master clocks: chain and rise at the start, strobe mid-high, sample before the fall
	task automatic shift(input logic cin, input logic fs, output logic [NCH-1:0] v);
		@(posedge clk_i);
		chain_o <= cin;
		sclk_o  <= 1'b1;
		repeat (2) @(posedge clk_i);
		frame_o <= fs;
		@(posedge clk_i);
		@(negedge clk_i);
		v = dout_i;
		@(posedge clk_i);
		sclk_o <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
endmodule // asr_host_model

// >>> bench/testbench.sv
// self-checking bench for the serial readout port in ready-flag and frame-strobe formats
`timescale 1ns/10ps
`include "asr_reg_map.svh"

module testbench
	import asr_pkg::*;
;
	// ======================================================================
	// bench signals
	logic        clk, rst_n, hsel, hwrite, hready, hresp, res_valid, flag, flag_oe;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [143:0] res_data;
	logic [7:0]  sleep_n, dout, aw;
	logic [7:0]  cpat = 8'hb4;
	logic [17:0] din [8] = '{18'h1ffff, 18'h20000, 18'h01234, 18'h3edcb,
	                         18'h05a5a, 18'h3a5a5, 18'h00f0f, 18'h07ffe};
	logic        exp_q [$];
	logic [7:0]  dout_i_v;
	wire         sclk, chain, pin, frame;
	int          fails, total_checks, cycles;

	// shared pin: the port's flag while it drives, otherwise the host's frame strobe
	assign pin = flag_oe ? flag : frame;

	asr_readout_port i_asr_readout_port (
		.CLOCK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .RES_VALID_I(res_valid),
		.RES_DATA_I(res_data), .SCLK_I(sclk), .READY_OR_FRAME_PIN_I(pin),
		.READY_OR_FRAME_PIN_O(flag), .READY_OR_FRAME_PIN_OE_O(flag_oe), .CHAIN_I(chain),
		.CHANNEL_SLEEP_PIN_N_I(sleep_n), .SERIAL_OUT_O(dout));

	asr_host_model i_asr_host_model (.clk_i(clk), .sclk_o(sclk), .frame_o(frame), .chain_o(chain), .dout_i(dout));

	// ======================================================================
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fails++;
			final_report();
		end
	end

	// ======================================================================
	// helpers
	task automatic final_report();
		if (fails == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [15:0] clip(input logic signed [17:0] x);
		if (x > 18'sh07fff) return 16'h7fff;
		if (x < 18'sh38000) return 16'h8000;
		return x[15:0];
	endfunction

	// single word transfer: address phase, then data phase, both held until ready
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		hsize  <= `ASR_HSIZE_WORD;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		chk("response", 0, {31'h0, hresp});
	endtask

	// select format and sleep pins, present a result set, check the flag pulse
	task automatic load(input logic [2:0] fmt, input logic [7:0] awake, input logic fc);
		ahb(1'b1, `ASR_CFG_OFS, {29'h0, fmt});
		sleep_n <= awake;
		for (int c = 0; c < 8; c++) res_data[c*18 +: 18] <= din[c];
		repeat (6) @(posedge clk);
		res_valid <= 1'b1;
		@(posedge clk);
		res_valid <= 1'b0;
		@(posedge clk);
		if (fc) chk("flag pulse", 1, {31'h0, flag});
		@(posedge clk);
		if (fc) chk("flag low", 0, {31'h0, flag});
		chk("flag enable", {31'h0, fmt < 3'h3}, {31'h0, flag_oe});
		@(posedge clk);
	endtask

	// expected multiplexed stream: slots, zero tail, then chain bits
	task automatic build(input logic fixed, input logic [7:0] awake);
		logic [15:0] w;
		exp_q.delete();
		for (int c = 0; c < 8; c++) begin
			w = clip(din[c]);
			if (awake[c] || fixed) begin
				for (int b = 15; b >= 0; b--) exp_q.push_back(awake[c] & w[b]);
			end
		end
		while (exp_q.size() < 128) exp_q.push_back(1'b0);
		for (int j = 0; j < 8; j++) exp_q.push_back(cpat[7-j] & (|awake));
	endtask

	// per-pin lanes: bit i of each awake channel, zeros after the 16th edge and when asleep
	task automatic lanes(input int i, input logic [7:0] v);
		logic [15:0] w;
		for (int c = 0; c < 8; c++) begin
			w = clip(din[c]);
			chk("lane", {31'h0, (i < 16) && aw[c] && w[15 - (i % 16)]}, {31'h0, v[c]});
		end
	endtask

	// read n bits of the multiplexed stream and the shift count
	task automatic read_mux(input int n, input logic fc);
		logic [7:0] v;
		for (int i = 0; i < n; i++) begin
			i_asr_host_model.shift(cpat[7 - (i % 8)], 1'b0, v);
			chk("first output", {31'h0, exp_q[i]}, {31'h0, v[0]});
			chk("other outputs", 0, {24'h0, v[7:1]});
			if (i == 0 && fc) begin
				repeat (2) @(posedge clk);
				chk("flag after shift", 1, {31'h0, flag});
			end
		end
		ahb(1'b0, `ASR_STAT_OFS, 32'h0);
		chk("shift count", n, {24'h0, rd[15:8]});
	endtask

	// ======================================================================
	// main sequence
	initial begin
		rst_n = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = 32'h0; hwrite = 1'b0;
		hsize = 3'h0; hwdata = 32'h0; res_valid = 1'b0; res_data = '0; sleep_n = 8'hff;
		fails = 0; total_checks = 0; cycles = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		// register reset value, unmapped read, write and read back
		ahb(1'b0, `ASR_CFG_OFS, 32'h0);
		chk("cfg reset", 0, rd);
		ahb(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 0, rd);
		ahb(1'b1, `ASR_CFG_OFS, 32'h2);
		ahb(1'b0, `ASR_CFG_OFS, 32'h0);
		chk("cfg", 2, rd);
		// multiplexed, dynamic then fixed, all awake then channels 1 and 3 asleep
		for (int k = 0; k < 4; k++) begin
			aw = k[1] ? 8'hfa : 8'hff;
			load({2'b00, k[0]}, aw, 1'b1);
			build(k[0], aw);
			read_mux(aw == 8'hff ? 136 : 128, 1'b1);
		end
		// unread set is overwritten by the next one
		load(3'b001, 8'hff, 1'b1);
		for (int c = 0; c < 8; c++) din[c] = ~din[c];
		load(3'b001, 8'hff, 1'b1);
		build(1'b1, 8'hff);
		read_mux(136, 1'b1);
		// per-pin lanes, channel 5 asleep, zeros after the 16th edge
		aw = 8'hef;
		load(3'b010, aw, 1'b1);
		for (int i = 0; i < 20; i++) begin
			i_asr_host_model.shift(1'b1, 1'b0, dout_i_v);
			lanes(i, dout_i_v);
		end
		// all channels asleep: zeros, chain ignored
		load(3'b001, 8'h00, 1'b0);
		build(1'b1, 8'h00);
		read_mux(136, 1'b0);
		// frame-strobe per-pin: first frames teach the period, the third sends the held set
		aw = 8'hef;
		load(3'b101, aw, 1'b0);
		for (int f = 0; f < 3; f++) begin
			for (int i = 0; i < 16; i++) begin
				i_asr_host_model.shift(1'b0, i < 8, dout_i_v);
				if (f == 2) lanes(i, dout_i_v);
			end
		end
		ahb(1'b0, `ASR_FRM_OFS, 32'h0);
		chk("frame period", 16, rd);
		final_report();
	end
endmodule // testbench

// >>> inc/asr_pkg.sv
// types shared by the serial readout port
`include "asr_reg_map.svh"

package asr_pkg;

	// ======================================================================
	// format selection: protocol, output mode and data position
	typedef enum logic [2:0] {
		ASR_FMT_RD_DYN = 3'b000,
		ASR_FMT_RD_FIX = 3'b001,
		ASR_FMT_RD_PIN = 3'b010,
		ASR_FMT_FS_DYN = 3'b011,
		ASR_FMT_FS_FIX = 3'b100,
		ASR_FMT_FS_PIN = 3'b101,
		ASR_FMT_RSV6   = 3'b110,
		ASR_FMT_RSV7   = 3'b111
	} asr_fmt_t;

	// ======================================================================
	// captured bus address phase
	typedef struct packed {
		logic                   write;
		logic [2:0]             size;
		logic [`ASR_ADDR_W-1:0] addr;
	} asr_aph_t;

	// ======================================================================
	// link pins sampled together through the synchroniser stages
	typedef struct packed {
		logic sclk;
		logic frame;
		logic chain;
	} asr_pins_t;

endpackage

// >>> inc/asr_reg_map.svh
// register offsets, field positions and reset values of the serial readout port
`ifndef ASR_REG_MAP_SVH
`define ASR_REG_MAP_SVH

// ==========================================================================
// register byte offsets (haddr low bits)
`define ASR_ADDR_W      8
`define ASR_CFG_OFS     8'h00
`define ASR_STAT_OFS    8'h04
`define ASR_FRM_OFS     8'h08

// ==========================================================================
// configuration register fields and reset value
`define ASR_CFG_FMT     2:0
`define ASR_CFG_RST     3'h0

// ==========================================================================
// status register fields
`define ASR_ST_FLAG     0
`define ASR_ST_SLEEP    1
`define ASR_ST_HOLD     2
`define ASR_ST_CNT      15:8
`define ASR_ST_CNT_W    8

// ==========================================================================
// bus encodings
`define ASR_HSIZE_WORD  3'h2
`define ASR_HTRANS_ACT  1

`endif

// >>> verilog/asr_readout_port.sv
// serial readout port: ready-flag and frame-strobe protocols, per-pin and multiplexed output
//
// Notes on behaviour
// - ready-flag protocol: data leave MSB first, advancing on each falling shift clock edge
// - chain input is captured on falling shift clock edges in both protocols, in multiplexed mode only; per-pin mode fills with zeros
// - flag goes low on new results, returns high at next falling shift edge
// - unread results: flag pulses high just before the next set, then low again
// - new set loads one cycle before flag falls, overwriting unread bits
// - per-pin mode uses one output per channel; multiplexed uses first output only
// - MSB already valid when flag falls; later bits on falling shift edges
// - multiplexed mode: chain bits follow after all local channel bits
// - frame-strobe: MSB valid at rising shift edge before strobe rises
// - multiplexed order: channel 1 first up to last, then chain data
// - all channels asleep powers down the serial port and chain input
// - fixed-position mode: sleeping channel keeps its slot, filled with zeros
// - dynamic-position mode: higher channels move up to fill sleeping slots
// - per-pin mode: zeros after the 16th shift edge and on sleeping channels
// - three-bit format code selects protocol, output mode and data position
// - results are 16-bit two's complement, clipped at both full-scale codes
`timescale 1ns/10ps
`include "asr_reg_map.svh"

module asr_readout_port
	import asr_pkg::*;
#(
	parameter int NCH  = 8,
	parameter int W    = 16,
	parameter int IN_W = 18,
	parameter int CW   = 12
) (
	// clock and reset
	input  wire logic                  CLOCK_I,
	input  wire logic                  RST_N_I,
	// register bus
	input  wire logic                  HSEL_I,
	input  wire logic [31:0]           HADDR_I,
	input  wire logic [1:0]            HTRANS_I,
	input  wire logic                  HWRITE_I,
	input  wire logic [2:0]            HSIZE_I,
	input  wire logic [31:0]           HWDATA_I,
	input  wire logic                  HREADY_I,
	output logic      [31:0]           HRDATA_O,
	output logic                       HREADYOUT_O,
	output logic                       HRESP_O,
	// result sets from the converter core
	input  wire logic                  RES_VALID_I,
	input  wire logic [NCH*IN_W-1:0]   RES_DATA_I,
	// link pins
	input  wire logic                  SCLK_I,
	input  wire logic                  READY_OR_FRAME_PIN_I,
	output logic                       READY_OR_FRAME_PIN_O,
	output logic                       READY_OR_FRAME_PIN_OE_O,
	input  wire logic                  CHAIN_I,
	input  wire logic [NCH-1:0]        CHANNEL_SLEEP_PIN_N_I,
	output logic      [NCH-1:0]        SERIAL_OUT_O
);

	localparam int SW     = NCH * W;
	localparam int BW     = `ASR_ST_CNT_W;
	localparam int ADDR_W = `ASR_ADDR_W;

	// ======================================================================
	// state of the block
	typedef struct packed {
		asr_pins_t          p1;
		asr_pins_t          p2;
		asr_pins_t          p3;
		logic [NCH-1:0]     slp1;
		logic [NCH-1:0]     slp2;
		logic [SW-1:0]      shift;
		logic [SW-1:0]      hold;
		logic               hold_ok;
		logic               flag;
		logic               pend_low;
		logic               loaded;
		logic [BW-1:0]      bits;
		logic [CW-1:0]      fcnt;
		logic [CW-1:0]      fper;
		logic [2:0]         fmt;
		asr_aph_t           aph;
		logic               aph_v;
		logic [31:0]        rdata;
		logic               readyout;
		logic               resp;
		logic [NCH-1:0]     sout;
		logic               pin_out;
		logic               pin_oe;
	} asr_state_t;

	asr_state_t         s_r;
	asr_state_t         s_nxt;
	logic               rs1_r;
	logic               rs2_r;
	logic               rst_n;

	// ======================================================================
	// helper functions

	// ready-flag protocol codes
	function automatic logic is_rd(input logic [2:0] f);
		return (f == ASR_FMT_RD_DYN) || (f == ASR_FMT_RD_FIX) || (f == ASR_FMT_RD_PIN);
	endfunction

	// per-pin output codes
	function automatic logic is_disc(input logic [2:0] f);
		return (f == ASR_FMT_RD_PIN) || (f == ASR_FMT_FS_PIN);
	endfunction

	// dynamic-position codes
	function automatic logic is_dyn(input logic [2:0] f);
		return (f == ASR_FMT_RD_DYN) || (f == ASR_FMT_FS_DYN);
	endfunction

	// saturate a wide core result to the output word
	function automatic logic [W-1:0] clip(input logic [IN_W-1:0] v);
		logic ovf;
		ovf = (v[IN_W-1:W-1] != {(IN_W-W+1){v[IN_W-1]}});
		if (ovf)
			return v[IN_W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
		return v[W-1:0];
	endfunction

	// place channel words in stream slots, channel 1 in the top slot
	function automatic logic [SW-1:0] pack(input logic [NCH*IN_W-1:0] raw,
	                                       input logic [NCH-1:0] awake, input logic dyn);
		logic [SW-1:0] r;
		int            j;
		r = '0;
		j = 0;
		for (int i = 0; i < NCH; i++) begin
			if (awake[i]) begin
				if (dyn)
					r[SW-1-j*W -: W] = clip(raw[i*IN_W +: IN_W]);
				else
					r[SW-1-i*W -: W] = clip(raw[i*IN_W +: IN_W]);
				j++;
			end
		end
		return r;
	endfunction

	// one falling shift edge: whole stream with chain fill, or each slot with zero fill
	function automatic logic [SW-1:0] step(input logic [SW-1:0] v, input logic disc, input logic cin);
		logic [SW-1:0] r;
		r = {v[SW-2:0], cin};
		if (disc) begin
			for (int i = 0; i < NCH; i++)
				r[SW-1-i*W -: W] = {v[SW-2-i*W -: W-1], 1'b0};
		end
		return r;
	endfunction

	// serial output pins from the stream register
	function automatic logic [NCH-1:0] pins(input logic [SW-1:0] v, input logic disc, input logic off);
		logic [NCH-1:0] o;
		o = '0;
		for (int i = 0; i < NCH; i++)
			o[i] = disc ? v[SW-1-i*W] : ((i == 0) ? v[SW-1] : 1'b0);
		if (off)
			o = '0;
		return o;
	endfunction

	// register read multiplexer, unmapped addresses read zero
	function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a, input asr_state_t st);
		logic [31:0] r;
		r = '0;
		case (a)
			`ASR_CFG_OFS: r[`ASR_CFG_FMT] = st.fmt;
			`ASR_STAT_OFS: begin
				r[`ASR_ST_FLAG]  = st.flag;
				r[`ASR_ST_SLEEP] = ~|st.slp2;
				r[`ASR_ST_HOLD]  = st.hold_ok;
				r[`ASR_ST_CNT]   = st.bits;
			end
			`ASR_FRM_OFS: r[CW-1:0] = st.fper;
			default: r = '0;
		endcase
		return r;
	endfunction

	// ======================================================================
	// decoded conditions
	logic               rd;
	logic               disc;
	logic               dyn;
	logic               asleep_all;
	logic               sclk_fall;
	logic               sclk_rise;
	logic               frame_rise;
	logic [CW-1:0]      fcnt_inc;
	logic               fs_load;
	logic               aph_take;
	logic               cfg_wr;
	logic [SW-1:0]      set_packed;

	// mode decode and link edge detection on the synchronised copies
	assign rd         = is_rd(s_r.fmt);
	assign disc       = is_disc(s_r.fmt);
	assign dyn        = is_dyn(s_r.fmt);
	assign asleep_all = ~|s_r.slp2;
	assign sclk_fall  = s_r.p3.sclk & ~s_r.p2.sclk;
	assign sclk_rise  = ~s_r.p3.sclk & s_r.p2.sclk;
	assign frame_rise = ~s_r.p3.frame & s_r.p2.frame;
	assign fcnt_inc   = CW'(s_r.fcnt + 1'b1);
	assign fs_load    = ~rd & sclk_rise & (fcnt_inc == s_r.fper) & (s_r.fper != '0);
	assign aph_take   = HSEL_I & HTRANS_I[`ASR_HTRANS_ACT] & HREADY_I;
	assign cfg_wr     = s_r.aph_v & s_r.aph.write & (s_r.aph.size == `ASR_HSIZE_WORD) & (s_r.aph.addr == `ASR_CFG_OFS);
	assign set_packed = pack(RES_DATA_I, s_r.slp2, dyn);

	// ======================================================================
	// reset release through two flip-flops
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rs1_r <= 1'b0;
			rs2_r <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rs2_r <= rs1_r;
		end
	end

	assign rst_n = rs2_r;

	// ======================================================================
	// next state
	always_comb begin
		s_nxt        = s_r;
		s_nxt.loaded = 1'b0;

		// two-stage pin synchronisers, third stage for edge detection
		s_nxt.p1   = '{sclk: SCLK_I, frame: READY_OR_FRAME_PIN_I, chain: CHAIN_I};
		s_nxt.p2   = s_r.p1;
		s_nxt.p3   = s_r.p2;
		s_nxt.slp1 = CHANNEL_SLEEP_PIN_N_I;
		s_nxt.slp2 = s_r.slp1;

		// flag drops one cycle after the load
		if (s_r.pend_low) begin
			s_nxt.flag     = 1'b0;
			s_nxt.pend_low = 1'b0;
		end

		// frame period measured in rising shift edges
		if (!rd) begin
			if (frame_rise) begin
				s_nxt.fper = s_r.fcnt;
				s_nxt.fcnt = '0;
			end else if (sclk_rise) begin
				s_nxt.fcnt = fcnt_inc;
			end
		end

		// load, frame load or shift, in that priority
		if (rd && RES_VALID_I) begin
			s_nxt.shift    = set_packed;
			s_nxt.flag     = 1'b1;
			s_nxt.pend_low = 1'b1;
			s_nxt.bits     = '0;
			s_nxt.loaded   = 1'b1;
		end else if (fs_load) begin
			s_nxt.shift   = s_r.hold;
			s_nxt.hold_ok = 1'b0;
			s_nxt.bits    = '0;
			s_nxt.loaded  = 1'b1;
		end else if (sclk_fall) begin
			s_nxt.shift = step(s_r.shift, disc, s_r.p2.chain & ~asleep_all);
			if (s_r.bits != '1)
				s_nxt.bits = BW'(s_r.bits + 1'b1);
			if (rd && !s_r.flag && !s_r.pend_low)
				s_nxt.flag = 1'b1;
		end

		// frame-strobe protocol parks a new set until the frame boundary
		if (!rd && RES_VALID_I) begin
			s_nxt.hold    = set_packed;
			s_nxt.hold_ok = 1'b1;
		end

		// any config write drops the old stream unless a set loads in the same cycle, so no stale bits leak into new lanes
		if (cfg_wr && !s_nxt.loaded)
			s_nxt.shift = '0;

		// pins follow the new stream at the same edge, MSB first
		s_nxt.sout    = pins(s_nxt.shift, disc, asleep_all);
		s_nxt.pin_oe  = rd;
		s_nxt.pin_out = s_nxt.flag;

		// bus slave: zero wait states, always OKAY
		s_nxt.readyout = 1'b1;
		s_nxt.resp     = 1'b0;
		s_nxt.aph_v    = aph_take;
		if (aph_take) begin
			s_nxt.aph   = '{write: HWRITE_I, size: HSIZE_I, addr: HADDR_I[ADDR_W-1:0]};
			s_nxt.rdata = HWRITE_I ? 32'h0 : rd_mux(HADDR_I[ADDR_W-1:0], s_r);
		end
		if (cfg_wr)
			s_nxt.fmt = HWDATA_I[`ASR_CFG_FMT];
	end

	// ======================================================================
	// state register
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			s_r          <= '0;
			s_r.fmt      <= `ASR_CFG_RST;
			s_r.flag     <= 1'b1;
			s_r.pin_out  <= 1'b1;
			s_r.pin_oe   <= 1'b1;
			s_r.readyout <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ======================================================================
	// outputs straight from the state register
	assign HRDATA_O                = s_r.rdata;
	assign HREADYOUT_O             = s_r.readyout;
	assign HRESP_O                 = s_r.resp;
	assign READY_OR_FRAME_PIN_O    = s_r.pin_out;
	assign READY_OR_FRAME_PIN_OE_O = s_r.pin_oe;
	assign SERIAL_OUT_O            = s_r.sout;

	// ======================================================================
	// checks
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!rst_n);

	// flag falls only one cycle after a load
	property p_fall_after_load;
		rd && $fell(s_r.flag) |-> $past(s_r.loaded);
	endproperty
	a_fall_after_load: assert property (p_fall_after_load)
		else $error("ready flag fell without a load one cycle earlier");

	// first falling shift edge after the fall raises the flag
	property p_flag_rise;
		rd && sclk_fall && !s_r.flag && !s_r.pend_low && !RES_VALID_I |=> s_r.flag && s_r.pin_out;
	endproperty
	a_flag_rise: assert property (p_flag_rise)
		else $error("ready flag did not return high on falling shift edge");

	// unread set: flag pulses high for one cycle then drops
	property p_flag_pulse;
		rd && RES_VALID_I && !s_r.flag |=> s_r.flag ##1 !s_r.flag;
	endproperty
	a_flag_pulse: assert property (p_flag_pulse)
		else $error("ready flag pulse missing before new result set");

	// MSB stands on the first output when the flag falls
	property p_msb_at_fall;
		rd && !disc && $fell(s_r.flag) && !asleep_all |-> s_r.sout[0] == s_r.shift[SW-1];
	endproperty
	a_msb_at_fall: assert property (p_msb_at_fall)
		else $error("MSB not on first output at flag fall");

	// falling edge shifts the stream up by one
	property p_shift_msb_first;
		!disc && sclk_fall && !RES_VALID_I && !fs_load |=> s_r.shift[SW-1:1] == $past(s_r.shift[SW-2:0]);
	endproperty
	a_shift_msb_first: assert property (p_shift_msb_first)
		else $error("stream did not advance by one bit");

	// chain bit lands at the tail of the stream
	property p_chain_in;
		!disc && sclk_fall && !RES_VALID_I && !fs_load && !asleep_all |=> s_r.shift[0] == $past(s_r.p2.chain);
	endproperty
	a_chain_in: assert property (p_chain_in)
		else $error("chain input not captured on falling shift edge");

	// multiplexed mode drives only the first output
	property p_one_pin;
		!$past(disc) |-> s_r.sout[NCH-1:1] == '0;
	endproperty
	a_one_pin: assert property (p_one_pin)
		else $error("multiplexed mode drove a channel output");

	// per-pin outputs read zero after the 16th edge
	property p_disc_zero;
		disc && $past(disc) && s_r.bits >= BW'(W) |-> s_r.sout == '0;
	endproperty
	a_disc_zero: assert property (p_disc_zero)
		else $error("per-pin output not zero after last bit");

	// all channels asleep silences every serial output
	property p_all_asleep;
		asleep_all |=> s_r.sout == '0;
	endproperty
	a_all_asleep: assert property (p_all_asleep)
		else $error("outputs active with all channels asleep");

	// fixed position: sleeping channel 1 leaves a zero slot
	property p_fixed_zero;
		rd && !dyn && s_r.loaded && !$past(s_r.slp2[0]) |-> s_r.shift[SW-1 -: W] == '0;
	endproperty
	a_fixed_zero: assert property (p_fixed_zero)
		else $error("sleeping channel slot not zero in fixed mode");

	// dynamic position: channel 2 moves into the vacated first slot
	property p_dyn_move;
		rd && dyn && RES_VALID_I && !s_r.slp2[0] && s_r.slp2[1]
			|=> s_r.shift[SW-1 -: W] == clip($past(RES_DATA_I[2*IN_W-1 -: IN_W]));
	endproperty
	a_dyn_move: assert property (p_dyn_move)
		else $error("dynamic mode did not close the gap");

	// awake channel 1 is clipped into the first slot
	property p_clip;
		rd && RES_VALID_I && s_r.slp2[0] |=> s_r.shift[SW-1 -: W] == clip($past(RES_DATA_I[IN_W-1:0]));
	endproperty
	a_clip: assert property (p_clip)
		else $error("channel word not clipped correctly");

	// frame load puts the held set out with MSB valid
	property p_frame_msb;
		fs_load && !RES_VALID_I |=> s_r.shift == $past(s_r.hold) && s_r.bits == '0;
	endproperty
	a_frame_msb: assert property (p_frame_msb)
		else $error("frame boundary load missing");

	// shared pin driven only in the ready-flag protocol
	property p_pin_dir;
		1'b1 |=> s_r.pin_oe == $past(rd);
	endproperty
	a_pin_dir: assert property (p_pin_dir)
		else $error("ready pin direction does not follow format");

endmodule // asr_readout_port
